// ---- core/afds_core.sv ----
/*
 * Fault diagnosis status logic of a four-channel amplifier: serial link slave, two
 * control bytes, turn-on and permanent diagnosis, four status bytes.
 * Assumes analog fault comparators arrive as asynchronous levels, and that the serial
 * clock and data pins are resolved outside from the output enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "afds_cfg.svh"

// What this block does
// - Byte three bits zero to three report faults
// - Bit four set for permanent, clear turn-on
// - Bit five low current only when enabled
// - Byte three bit six mirrors diag enable
// - Byte three bit seven mirrors play control
// - Byte four same layout, bits six, seven zero
// - Short protection disables only faulted channel
// - Turn-on results valid after acquisition time
// - Turn-on results kept for repeated reads
// - Timing bit selects one-shot or repeat
// - Permanent diagnosis runs regardless, bare read
// - Removed fault still shown on next read
// - Permanent diagnosis starts after turn-on finishes
// - Offset detection continuous and never latched
// - Write selects clip or offset pin function
// - First byte bit seven is thermal warning
// - Read returns bytes one, two, three, four
// - Config two bit two enables, bit seven unused
// - Respond at address D8H, low bit direction
module afds_core #(
	parameter int ACQ_CYCLES = `AFDS_ACQ_CYCLES, // Turn-on acquisition length in clk cycles
	parameter int NUM_CH = 4 // Amplifier channels
) (
	input wire logic clk, // System clock, 100 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic scl_clk, // Serial link clock from the host
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Serial data drive value, always low
	output logic sda_oe, // Serial data pulled low while high
	input wire logic [NUM_CH-1:0] flt_gnd, // Output shorted to ground
	input wire logic [NUM_CH-1:0] flt_vcc, // Output shorted to supply
	input wire logic [NUM_CH-1:0] flt_open, // Open load seen
	input wire logic [NUM_CH-1:0] flt_load, // Output to output short
	input wire logic [NUM_CH-1:0] flt_offset, // Output offset present
	input wire logic [NUM_CH-1:0] flt_low_cur, // Peak current under threshold
	input wire logic thermal_warn, // Die near thermal_shutdown point
	input wire logic clip_det, // Clip comparator level
	output logic clip_pin, // Clip or offset indicator pin
	output logic [NUM_CH-1:0] chan_disable, // Per-channel protection shutoff
	output logic [7:0] config_byte_one, // Control byte one, system domain
	output logic [7:0] config_byte_two // Control byte two, system domain
);

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: start detection, byte shifter, control bytes

	logic start_mark; // Toggles on each start condition
	logic start_seen; // Last start consumed by the byte logic
	afds_pkg::afds_link_type lstate; // Link byte state
	logic [3:0] bitcnt; // Bit in byte, 8 is the acknowledge slot
	logic [7:0] shreg; // Received bits
	logic [6:0] ptr; // Write pointer into control bytes
	logic autoinc; // Pointer steps after each data byte
	logic [1:0] rd_idx; // Status byte being sent
	logic rd_tog; // Toggles when a read ends
	logic [7:0] cfg1_l; // Control byte one in link domain
	logic [7:0] cfg2_l; // Control byte two in link domain
	logic [7:0] shadow [`AFDS_NUM_BYTES]; // Frozen status, system domain

	wire start_pend = start_mark != start_seen; // Start arrived since last bit
	wire byte_end = bitcnt == 4'h8; // Acknowledge slot reached
	wire addr_hit = shreg[7:1] == `AFDS_DEV_ADDR;
	wire [7:0] full = {shreg[6:0], sda_in}; // Byte including the current bit
	wire [7:0] tx_byte = shadow[rd_idx];
	wire tx_bit = tx_byte[3'h7 - bitcnt[2:0]]; // Most significant bit first
	wire ack_want = (lstate == afds_pkg::afds_addr && addr_hit) ||
		lstate == afds_pkg::afds_sub || lstate == afds_pkg::afds_wdata;

	// Start: data falls while clock high; a toggle carries it to the clock edge
	always_ff @(negedge sda_in or negedge rstn) begin
		if (!rstn) begin
			start_mark <= 1'b0;
		end else if (scl_clk) begin
			start_mark <= ~start_mark;
		end
	end

	// Byte engine on the rising serial clock; the clock is still outside frames
	always_ff @(posedge scl_clk or negedge rstn) begin
		if (!rstn) begin
			lstate <= afds_pkg::afds_idle;
			start_seen <= 1'b0;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 7'h00;
			autoinc <= 1'b0;
			rd_idx <= 2'h0;
			rd_tog <= 1'b0;
			cfg1_l <= `AFDS_CFG_RESET;
			cfg2_l <= `AFDS_CFG_RESET;
		end else if (start_pend) begin
			// A start aborts anything in flight and takes the first address bit
			start_seen <= start_mark;
			lstate <= afds_pkg::afds_addr;
			shreg <= {7'h00, sda_in};
			bitcnt <= 4'h1;
			rd_idx <= 2'h0;
		end else if (!byte_end) begin
			shreg <= full;
			bitcnt <= bitcnt + 4'h1;
		end else begin
			bitcnt <= 4'h0;
			case (lstate)
				afds_pkg::afds_addr: begin
					// Mismatch leaves the bus alone until the next start
					if (!addr_hit) begin
						lstate <= afds_pkg::afds_idle;
					end else if (shreg[0]) begin
						lstate <= afds_pkg::afds_rdata;
					end else begin
						lstate <= afds_pkg::afds_sub;
					end
				end
				afds_pkg::afds_sub: begin
					ptr <= shreg[6:0];
					autoinc <= shreg[`AFDS_SUB_AUTOINC];
					lstate <= afds_pkg::afds_wdata;
				end
				afds_pkg::afds_wdata: begin
					// Only the two control bytes store; 15H and others are dropped
					if (ptr == `AFDS_SUB_ONE) begin
						cfg1_l <= shreg;
					end
					if (ptr == `AFDS_SUB_TWO) begin
						cfg2_l <= shreg;
					end
					if (autoinc) begin
						ptr <= ptr + 7'h01;
					end
				end
				afds_pkg::afds_rdata: begin
					// Host not-acknowledge ends the read; ack moves to the next byte
					if (sda_in) begin
						lstate <= afds_pkg::afds_idle;
						rd_tog <= ~rd_tog;
					end else begin
						rd_idx <= rd_idx + 2'h1;
					end
				end
				default: begin
					lstate <= afds_pkg::afds_idle;
				end
			endcase
		end
	end

	// Pin drive changes on the falling clock so data is steady while clock high
	always_ff @(negedge scl_clk or negedge rstn) begin
		if (!rstn) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= (byte_end && ack_want) ||
				(lstate == afds_pkg::afds_rdata && !byte_end && !tx_bit);
		end
	end

	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Crossings into the system domain

	logic [7:0] cfg1_m, cfg2_m; // First synchroniser stage
	logic busy_m, busy_s; // Address or read phase in progress
	logic [2:0] rd_sync; // Read-end toggle, two stages plus history
	logic [6*NUM_CH+1:0] raw_m, raw_s; // Analog levels

	// A write never returns the link to idle, so only address and read phases freeze
	wire busy_l = lstate == afds_pkg::afds_addr || lstate == afds_pkg::afds_rdata;
	wire rd_event = rd_sync[2] != rd_sync[1]; // One pulse per finished read

	// Two-flop synchronisers; control bytes only change when a data byte is stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg1_m <= `AFDS_CFG_RESET;
			cfg2_m <= `AFDS_CFG_RESET;
			config_byte_one <= `AFDS_CFG_RESET;
			config_byte_two <= `AFDS_CFG_RESET;
			busy_m <= 1'b0;
			busy_s <= 1'b0;
			rd_sync <= 3'h0;
			raw_m <= '0;
			raw_s <= '0;
		end else begin
			cfg1_m <= cfg1_l;
			cfg2_m <= cfg2_l;
			config_byte_one <= cfg1_m;
			config_byte_two <= cfg2_m;
			busy_m <= busy_l;
			busy_s <= busy_m;
			rd_sync <= {rd_sync[1:0], rd_tog};
			raw_m <= {clip_det, thermal_warn, flt_low_cur, flt_offset, flt_load,
				flt_open, flt_vcc, flt_gnd};
			raw_s <= raw_m;
		end
	end

	wire [NUM_CH-1:0] s_gnd = raw_s[NUM_CH-1:0];
	wire [NUM_CH-1:0] s_vcc = raw_s[2*NUM_CH-1:NUM_CH];
	wire [NUM_CH-1:0] s_open = raw_s[3*NUM_CH-1:2*NUM_CH];
	wire [NUM_CH-1:0] s_load = raw_s[4*NUM_CH-1:3*NUM_CH];
	wire [NUM_CH-1:0] s_offs = raw_s[5*NUM_CH-1:4*NUM_CH];
	wire [NUM_CH-1:0] s_lowc = raw_s[6*NUM_CH-1:5*NUM_CH];
	wire s_therm = raw_s[6*NUM_CH];
	wire s_clip = raw_s[6*NUM_CH+1];

	////////////////////////////////////////////////////////////////////////////////
	// Diagnosis phases and result latches

	wire play = config_byte_two[`AFDS_C2_PLAY];
	wire diag_en = config_byte_one[`AFDS_C1_DIAG_EN];
	wire repeat_mode = config_byte_one[`AFDS_C1_REPEAT];
	wire offs_en = config_byte_one[`AFDS_C1_OFFS_EN];
	wire cur_en = config_byte_two[`AFDS_C2_CUR_EN];

	afds_pkg::afds_phase_type phase, next_phase; // Diagnosis phase
	logic [31:0] acq_cnt; // Acquisition cycles elapsed
	logic [4*NUM_CH-1:0] ton; // Turn-on result: load, open, vcc, gnd per channel
	logic [3*NUM_CH-1:0] perm; // Sticky permanent faults: load, vcc, gnd
	logic diag_done; // Turn-on cycle has ended

	wire acq_end = phase == afds_pkg::afds_acq && acq_cnt == 32'(ACQ_CYCLES - 1);
	wire perm_on = phase == afds_pkg::afds_perm;
	wire [3*NUM_CH-1:0] perm_set = perm_on ? {s_load, s_vcc, s_gnd} : '0;

	// Phase selection: leaving standby starts acquisition when enabled
	always_comb begin
		next_phase = phase;
		case (phase)
			afds_pkg::afds_stby: begin
				if (play) begin
					next_phase = diag_en ? afds_pkg::afds_acq : afds_pkg::afds_perm;
				end
			end
			afds_pkg::afds_acq: begin
				if (!play) begin
					next_phase = afds_pkg::afds_stby;
				end else if (acq_end) begin
					next_phase = afds_pkg::afds_perm;
				end
			end
			afds_pkg::afds_perm: begin
				if (!play) begin
					next_phase = afds_pkg::afds_stby;
				end else if (repeat_mode && diag_en && rd_event) begin
					next_phase = afds_pkg::afds_acq;
				end
			end
			default: begin
				next_phase = afds_pkg::afds_stby;
			end
		endcase
	end

	// Phase register and acquisition counter; results are untrusted until the end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= afds_pkg::afds_stby;
			acq_cnt <= 32'h0;
		end else begin
			phase <= next_phase;
			acq_cnt <= (phase == afds_pkg::afds_acq) ? acq_cnt + 32'h1 : 32'h0;
		end
	end

	// Turn-on result held for every later read until the next acquisition or until play goes low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ton <= '0;
			diag_done <= 1'b0;
		end else if (acq_end) begin
			ton <= {s_load, s_open, s_vcc, s_gnd};
			diag_done <= 1'b1;
		end else if (next_phase == afds_pkg::afds_acq || !play) begin
			ton <= '0;
			diag_done <= 1'b0;
		end
	end

	// Permanent faults stick until a read ends; a fault seen that cycle survives
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			perm <= '0;
		end else begin
			perm <= (rd_event ? '0 : perm) | perm_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status byte assembly and pins

	// Low six bits of one channel's status byte
	function automatic logic [5:0] afds_chan_bits(input logic [3:0] t, input logic [2:0] p,
			input logic offs, input logic lowc);
		logic any;
		any = |p;
		afds_chan_bits[`AFDS_ST_GND] = any ? p[0] : t[0];
		afds_chan_bits[`AFDS_ST_VCC] = any ? p[1] : t[1];
		afds_chan_bits[`AFDS_ST_OPEN] = (!any && t[2]) || offs;
		afds_chan_bits[`AFDS_ST_LOAD] = any ? p[2] : t[3];
		afds_chan_bits[`AFDS_ST_PERM] = any;
		afds_chan_bits[`AFDS_ST_CUR] = lowc;
	endfunction : afds_chan_bits

	logic [5:0] low [NUM_CH]; // Per-channel low bits
	wire [NUM_CH-1:0] offs_now = offs_en ? s_offs : '0; // Present offset, not latched
	wire [NUM_CH-1:0] lowc_now = cur_en ? s_lowc : '0;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		assign low[c] = afds_chan_bits(
			{ton[3*NUM_CH+c], ton[2*NUM_CH+c], ton[NUM_CH+c], ton[c]},
			{perm[2*NUM_CH+c], perm[NUM_CH+c], perm[c]}, offs_now[c], lowc_now[c]);
	end

	wire [7:0] next_b1 = {s_therm, diag_done, low[0]};
	wire [7:0] next_b2 = {offs_en, cur_en, low[1]};
	wire [7:0] next_b3 = {play, diag_en, low[2]};
	wire [7:0] next_b4 = {2'h0, low[3]};

	// Shadow follows status except during an address or read phase, so a read sees one snapshot
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shadow <= '{default: 8'h00};
		end else if (!busy_s) begin
			shadow <= '{next_b1, next_b2, next_b3, next_b4};
		end
	end

	// Indicator pin and protection outputs, registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clip_pin <= 1'b0;
			chan_disable <= '0;
		end else begin
			clip_pin <= config_byte_two[`AFDS_C2_PIN_OFFS] ? |s_offs : s_clip;
			chan_disable <= s_gnd | s_vcc | s_load;
		end
	end

endmodule : afds_core
`default_nettype wire

// ---- shared/afds_cfg.svh ----
/*
 * Constants of the amplifier fault status block: link address, control byte offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by its bare name wherever these numbers are needed.
 */
`ifndef AFDS_CFG_SVH
`define AFDS_CFG_SVH

// Seven-bit link address, taken from the eight-bit form D8H
`define AFDS_DEV_ADDR 7'h6C
// Control byte offsets; 15H is a factory test location and is never honoured
`define AFDS_SUB_ONE 7'h01
`define AFDS_SUB_TWO 7'h02
`define AFDS_SUB_TEST 7'h15
// Sub-address field positions
`define AFDS_SUB_AUTOINC 7
// Config byte one fields
`define AFDS_C1_OFFS_EN 5
`define AFDS_C1_DIAG_EN 6
`define AFDS_C1_REPEAT 7
// Config byte two fields
`define AFDS_C2_CUR_EN 2
`define AFDS_C2_PLAY 4
`define AFDS_C2_PIN_OFFS 5
`define AFDS_C2_CUR_LOW 7
// Status byte fields
`define AFDS_ST_GND 0
`define AFDS_ST_VCC 1
`define AFDS_ST_OPEN 2
`define AFDS_ST_LOAD 3
`define AFDS_ST_PERM 4
`define AFDS_ST_CUR 5
`define AFDS_ST_B6 6
`define AFDS_ST_B7 7
// Reset value of both config bytes: all zero
`define AFDS_CFG_RESET 8'h00
// Status bytes sent per read, and the last byte index
`define AFDS_NUM_BYTES 4
`define AFDS_LAST_BYTE 2'h3
// Turn-on acquisition time in microseconds and the system clock rate in MHz
`define AFDS_ACQ_TIME_US 44000
`define AFDS_CLK_MHZ 100
`define AFDS_ACQ_CYCLES (`AFDS_ACQ_TIME_US * `AFDS_CLK_MHZ)

`endif

// ---- shared/afds_pkg.sv ----
/*
 * Types of the amplifier fault status block.
 * Assumes nothing of its surroundings; every use is written with the package name.
 */
`default_nettype none
package afds_pkg;
	// Link byte state, stepped on the serial clock
	typedef enum logic [2:0] {
		afds_idle = 3'b000,
		afds_addr = 3'b001,
		afds_sub = 3'b010,
		afds_wdata = 3'b011,
		afds_rdata = 3'b100
	} afds_link_type;

	// Diagnosis phase, stepped on the system clock
	typedef enum logic [1:0] {
		afds_stby = 2'b00,
		afds_acq = 2'b01,
		afds_perm = 2'b10
	} afds_phase_type;
endpackage : afds_pkg
`default_nettype wire

// ---- tb/afds_core_tb_top.sv ----
/*
 * Bench of the fault status block: link write and read tasks, status checks.
 * Assumes afds_host as link master and the checker bound beside the core.
 */
`timescale 1ns/1ps
`default_nettype none
module afds_core_tb_top;
	localparam int ACQ = 20; // Short acquisition keeps the run brief
	logic clk = 1'b0;
	logic rstn; // Driven low at time zero so the link flops see a reset edge
	logic [3:0] flt_gnd = 4'h0;
	logic [3:0] flt_vcc = 4'h0;
	logic [3:0] flt_open = 4'h0;
	logic [3:0] flt_load = 4'h0;
	logic [3:0] flt_offset = 4'h0;
	logic [3:0] flt_low_cur = 4'h0;
	logic thermal_warn = 1'b0;
	logic clip_det = 1'b0;
	wire scl_clk, host_low, sda_in, sda_out, sda_oe, clip_pin;
	wire [3:0] chan_disable;
	wire [7:0] config_byte_one, config_byte_two;
	logic [7:0] st [4]; // Status bytes of the last read
	logic [7:0] cur_cfg [3] = '{8'h10, 8'h14, 8'h94}; // Current detect settings
	logic ack; // Address answer of the last read
	int failures = 0;
	int checks = 0;
	// Pull-up wire: low when either party pulls
	assign sda_in = !(sda_oe | host_low);
	always #5 clk = !clk;

	afds_core #(.ACQ_CYCLES(ACQ), .NUM_CH(4)) u_dut (.clk(clk), .rstn(rstn), .scl_clk(scl_clk),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .flt_gnd(flt_gnd),
		.flt_vcc(flt_vcc), .flt_open(flt_open), .flt_load(flt_load), .flt_offset(flt_offset),
		.flt_low_cur(flt_low_cur), .thermal_warn(thermal_warn), .clip_det(clip_det),
		.clip_pin(clip_pin), .chan_disable(chan_disable), .config_byte_one(config_byte_one),
		.config_byte_two(config_byte_two));
	afds_host u_host (.scl_clk(scl_clk), .host_low(host_low), .sda(sda_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp8
	// Write one or two control bytes; 3 ns keeps link edges off clk edges
	task automatic wr(input logic [7:0] sub, input int n, input logic [7:0] b1);
		logic [7:0] rx;
		logic a;
		#3 u_host.start();
		u_host.xfer(8'hD8, 1'b1, rx, a);
		cmp8({7'h00, a}, 8'h00);
		u_host.xfer(sub, 1'b1, rx, a);
		u_host.xfer(b1, 1'b1, rx, a);
		if (n > 1) u_host.xfer(8'h10, 1'b1, rx, a);
		u_host.stop();
		repeat (4) @(posedge clk);
	endtask : wr
	// Read all four status bytes, refusing the last one
	task automatic rd(input logic [7:0] addr);
		logic a;
		#3 u_host.start();
		u_host.xfer(addr, 1'b1, st[0], a);
		ack = a;
		if (!a) for (int i = 0; i < 4; i++) u_host.xfer(8'hFF, i == 3, st[i], a);
		u_host.stop();
		@(posedge clk);
	endtask : rd
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'hD9);
		for (int i = 0; i < 4; i++) cmp8(st[i], 8'h00);
		rd(8'hD1);
		cmp8({7'h00, ack}, 8'h01);
		flt_gnd <= 4'h4;
		flt_open <= 4'h8;
		wr(8'h81, 2, 8'h40);
		cmp8(config_byte_one, 8'h40);
		cmp8(config_byte_two, 8'h10);
		repeat (2 * ACQ) @(posedge clk);
		rd(8'hD9);
		// Repeated bare reads keep the results
		repeat (2) begin
			rd(8'hD9);
			cmp8(st[0], 8'h40);
			cmp8(st[2], 8'hD1);
			cmp8(st[3], 8'h04);
		end
		flt_gnd <= 4'h0;
		flt_open <= 4'h0;
		rd(8'hD9);
		cmp8(st[2], 8'hD1);
		rd(8'hD9);
		// Latch cleared: the turn-on results (ch3 ground, ch4 open) show again
		cmp8(st[2], 8'hC1);
		cmp8(st[3], 8'h04);
		flt_low_cur <= 4'h8;
		foreach (cur_cfg[k]) begin
			wr(8'h02, 1, cur_cfg[k]);
			repeat (48) @(posedge clk);
			rd(8'hD9);
			cmp8({5'h00, st[3][7:5]}, {7'h00, cur_cfg[k][2]});
			cmp8(st[1] & 8'hC0, {1'b0, cur_cfg[k][2], 6'h00});
		end
		flt_low_cur <= 4'h0;
		wr(8'h01, 1, 8'h60);
		flt_offset <= 4'h4;
		repeat (8) @(posedge clk);
		rd(8'hD9);
		// Bit 0 is the turn-on ground result, still held
		cmp8(st[2] & 8'h0F, 8'h05);
		flt_offset <= 4'h0;
		repeat (8) @(posedge clk);
		rd(8'hD9);
		cmp8(st[2] & 8'h0F, 8'h01);
		// Pin source: offset mode ignores the clip comparator
		wr(8'h02, 1, 8'h30);
		flt_offset <= 4'h2;
		repeat (8) @(posedge clk);
		cmp8({7'h00, clip_pin}, 8'h01);
		flt_offset <= 4'h0;
		clip_det <= 1'b1;
		repeat (8) @(posedge clk);
		cmp8({7'h00, clip_pin}, 8'h00);
		wr(8'h02, 1, 8'h10);
		cmp8({7'h00, clip_pin}, 8'h01);
		clip_det <= 1'b0;
		thermal_warn <= 1'b1;
		flt_vcc <= 4'h2;
		flt_load <= 4'h1;
		repeat (8) @(posedge clk);
		cmp8({4'h0, chan_disable}, 8'h03);
		rd(8'hD9);
		cmp8(st[0] & 8'h80, 8'h80);
		thermal_warn <= 1'b0;
		flt_vcc <= 4'h0;
		flt_load <= 4'h0;
		wr(8'h01, 1, 8'hC0);
		repeat (2 * ACQ) @(posedge clk);
		rd(8'hD9);
		rd(8'hD9);
		cmp8(st[2], 8'hC0);
		wr(8'h02, 1, 8'h00);
		rd(8'hD9);
		cmp8(st[2], 8'h40);
		give_verdict();
	end
	// Watchdog: the tests take about 160 us
	initial begin
		#900000;
		failures++;
		give_verdict();
	end
endmodule : afds_core_tb_top
`default_nettype wire

// ---- tb/afds_host.sv ----
/*
 * Host model: master of the serial link, 160 ns bit period.
 * Assumes the bench resolves the data wire from host_low and the core's enable.
 */
`timescale 1ns/1ps
`default_nettype none
module afds_host (
	output logic scl_clk, // Link clock, stands high between frames
	output logic host_low, // Host pulls data low while high
	input wire logic sda // Resolved data wire with pull-up
);
	localparam int QTR = 40; // Quarter of a bit period
	initial begin
		scl_clk = 1'b1;
		host_low = 1'b0;
	end
	// Start: data falls while the clock is high
	task automatic start();
		host_low = 1'b1;
		#QTR scl_clk = 1'b0;
		#QTR;
	endtask : start
	// Stop: data rises while the clock is high, then the line is released
	task automatic stop();
		host_low = 1'b1;
		#QTR scl_clk = 1'b1;
		#QTR host_low = 1'b0;
		#(2 * QTR);
	endtask : stop
	// One bit: data moves only while the clock is low, sampled mid-high
	task automatic bit_io(input logic tx, output logic rx);
		host_low = !tx;
		#QTR scl_clk = 1'b1;
		#QTR rx = sda;
		#QTR scl_clk = 1'b0;
		#QTR;
	endtask : bit_io
	// Byte, MSB first, then the ninth bit (sent or sampled)
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack);
	endtask : xfer
endmodule : afds_host
`default_nettype wire

// ---- tb/afds_properties.sv ----
/*
 * Port checker of the amplifier fault status block, bound to afds_core.
 * Assumes a 100 MHz clk, and a link clock that never has an edge at a clk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module afds_core_properties #(
	parameter int ACQ_CYCLES = 20, // Acquisition length, unused here
	parameter int NUM_CH = 4 // Amplifier channels
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_clk,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [NUM_CH-1:0] flt_gnd,
	input wire logic [NUM_CH-1:0] flt_vcc,
	input wire logic [NUM_CH-1:0] flt_open,
	input wire logic [NUM_CH-1:0] flt_load,
	input wire logic [NUM_CH-1:0] flt_offset,
	input wire logic [NUM_CH-1:0] flt_low_cur,
	input wire logic thermal_warn,
	input wire logic clip_det,
	input wire logic clip_pin,
	input wire logic [NUM_CH-1:0] chan_disable,
	input wire logic [7:0] config_byte_one,
	input wire logic [7:0] config_byte_two
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Shorts that must switch a channel off
	wire [NUM_CH-1:0] shorts;
	assign shorts = flt_gnd | flt_vcc | flt_load;

	////////////////////////////////////////////////////////////////////////////////
	// Pins: six stable samples leave room for the two-flop sync and the output flop
	a_clip_pin_select: assert property (($stable(clip_det) && $stable(flt_offset) &&
		$stable(config_byte_two))[*6] |-> clip_pin == (config_byte_two[5] ? |flt_offset : clip_det))
		else $error("clip pin shows the wrong source");
	a_short_channel_off: assert property ($stable(shorts)[*6] |-> chan_disable == shorts)
		else $error("channel shutoff does not follow its own short");
	// Link: open drain, so only a low is ever driven
	a_drive_value_low: assert property (sda_out == 1'b0)
		else $error("data drive value not low");
	a_ack_on_low: assert property ($changed(sda_oe) |-> !scl_clk)
		else $error("data drive changed while link clock high");
	a_drive_hold_high: assert property ($rose(scl_clk) |-> $stable(sda_oe)[*6])
		else $error("data drive moved during a high phase");
	a_idle_released: assert property ((scl_clk && $stable(scl_clk))[*8] |-> !sda_oe)
		else $error("data line driven while link idle");
	// Control bytes move only when a data byte is taken on a rising link clock
	a_cfg_on_high: assert property ($changed({config_byte_one, config_byte_two}) |-> scl_clk)
		else $error("control byte changed outside a bit");
	a_cfg_idle_hold: assert property ((scl_clk && $stable(scl_clk))[*8] |->
		$stable({config_byte_one, config_byte_two}))
		else $error("control byte changed with no write");
	cover property ($rose(clip_pin));
	cover property (chan_disable != 0);
	cover property ($changed(config_byte_two));
	cover property ($rose(sda_oe));
endmodule : afds_core_properties

bind afds_core afds_core_properties #(.ACQ_CYCLES(ACQ_CYCLES), .NUM_CH(NUM_CH)) u_props (
	.clk(clk), .rstn(rstn), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .flt_gnd(flt_gnd), .flt_vcc(flt_vcc), .flt_open(flt_open),
	.flt_load(flt_load), .flt_offset(flt_offset), .flt_low_cur(flt_low_cur),
	.thermal_warn(thermal_warn), .clip_det(clip_det), .clip_pin(clip_pin),
	.chan_disable(chan_disable), .config_byte_one(config_byte_one),
	.config_byte_two(config_byte_two));
`default_nettype wire
